// File: rtl/rdp_pkg.sv
/*
 * Shared constants and types of the radio digital pin-function block:
 * register offsets, reset values, field layout of the control word.
 * Assumes a 32-bit APB slave whose byte offsets fit in eight bits.
 */
package rdp_pkg;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_BAUD = 8'h04;
	localparam logic [7:0] OFF_THR  = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] OFF_SER  = 8'h10;

	// ****************************************************************
	// Reset values and widths
	// ****************************************************************
	localparam logic [15:0] BAUD_RST = 16'h0040;
	localparam logic [7:0]  THR_RST  = 8'h80;
	localparam logic [8:0]  CTRL_RST = 9'h002;
	localparam int          SYNC_N   = 4;
	localparam logic [3:0]  SYNC_RST = 4'h1;
	localparam int          FIFO_DEPTH = 2;

	// Status field positions
	localparam int ST_CS   = 8;
	localparam int ST_LOCK = 9;
	localparam int ST_SLP  = 10;
	localparam int ST_CNT  = 11;

	// Role of the lock indicator pin
	typedef enum logic [1:0]
	{
		LK_IND = 2'b00,
		LK_GPO = 2'b01,
		LK_RXD = 2'b10,
		LK_RSV = 2'b11
	} rdp_lock_e;

	// Control word, highest bit first, bit 0 last
	typedef struct packed
	{
		logic      lock_gpo;
		logic      gauss;
		logic      tx_amp;
		logic      rx_amp;
		logic      async_clk;
		rdp_lock_e lock_mode;
		logic      sleep;
		logic      tx_mode;
	} rdp_ctrl_s;

endpackage

// File: rtl/rdp_pinfunc.sv
/*
 * Digital pin functions of a narrowband radio: data line and data clock,
 * lock pin roles, amplifier controls, serial config port, APB registers.
 * Assumes pin inputs are asynchronous to pclk and the modem sits on pclk.
 */
// The register offsets and the APB slave port were left to the implementer.
// Summary of operation
// - Data line is an input in transmit, driven with received bits in receive.
// - The device drives the data clock in both directions.
// - In asynchronous mode the data clock pin carries raw received data.
// - Data line level from host wakes the device from sleep in receive.
// - Lock pin is low while the synthesizer is locked, high otherwise.
// - Lock pin can serve as a software-driven general output.
// - Lock pin can carry receive data in synchronous modes.
// - Analog sleep puts data clock, data line and lock pin in high impedance.
// - Config select is active low and idles high when undriven.
// - Host clocks the config port; device returns read data serially.
// - Software drives an output for an external receive amplifier.
// - Software drives an output for an external transmit amplifier.
// - Receive data goes out on the data line with a recovered clock.
// - Transmit bits key the carrier, with optional Gaussian shaping.
// - Signal strength and carrier sense against a threshold are readable.
`timescale 1ns/1ps
module rdp_pinfunc
	import rdp_pkg::*;
#(
	parameter logic [15:0] BAUD_DEF = BAUD_RST
)
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Config serial port
	input  wire logic        cfg_cs_n,
	input  wire logic        cfg_sclk,
	input  wire logic        cfg_serial_in,
	output logic             cfg_serial_out,
	// Data clock pin
	output logic             bit_clock_pin_o,
	output logic             bit_clock_pin_oe_n,
	// Data line pin
	input  wire logic        bit_line_pin_i,
	output logic             bit_line_pin_o,
	output logic             bit_line_pin_oe_n,
	// Lock indicator pin
	output logic             lock_pin_o,
	output logic             lock_pin_oe_n,
	// Amplifier controls
	output logic             ext_rx_amp_ctrl,
	output logic             ext_tx_amp_ctrl,
	// Modem side
	input  wire logic        synth_locked,
	input  wire logic [7:0]  rssi,
	input  wire logic        demod_bit,
	input  wire logic        demod_valid,
	output logic             demod_ready,
	input  wire logic        mod_ready,
	output logic             mod_bit,
	output logic             mod_strobe,
	output logic             mod_gauss_en,
	output logic             wake_strobe
);

	// ****************************************************************
	// Registers
	// ****************************************************************
	rdp_ctrl_s   ctrl_q;
	logic [15:0] baud_q;
	logic [7:0]  thr_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        carrier_q;

	// Register decode
	wire logic sel_ctrl = paddr == OFF_CTRL;
	wire logic sel_baud = paddr == OFF_BAUD;
	wire logic sel_thr  = paddr == OFF_THR;
	wire logic sel_stat = paddr == OFF_STAT;
	wire logic sel_ser  = paddr == OFF_SER;
	wire logic mapped   = sel_ctrl | sel_baud | sel_thr | sel_stat | sel_ser;
	wire logic setup    = psel & ~penable & ~pready_q;
	wire logic wr       = psel & penable & pwrite & pready_q & mapped;
	wire logic wr_ctrl  = wr & sel_ctrl;

	logic       wake;
	logic [1:0] cnt_q;
	logic [7:0] ser_rx_q;
	wire  logic [31:0] stat_w = {19'h0, cnt_q, ctrl_q.sleep, synth_locked,
		carrier_q, rssi};
	wire  logic [31:0] rd_w = sel_ctrl ? {23'h0, ctrl_q} :
		sel_baud ? {16'h0, baud_q} :
		sel_thr  ? {24'h0, thr_q} :
		sel_stat ? stat_w :
		sel_ser  ? {24'h0, ser_rx_q} : 32'h0;

	// No wait cycle: answer is registered in setup, ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end
		else
		begin
			pready_q  <= setup;
			pslverr_q <= setup & ~mapped;
			prdata_q  <= (setup & ~pwrite) ? rd_w : 32'h0;
		end
	end

	// Control word; a host write wins over the wake event
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_q <= CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= pwdata[8:0];
		else if (wake)
			ctrl_q.sleep <= 1'b0;
	end

	// Rate and threshold
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			baud_q <= BAUD_DEF;
			thr_q  <= THR_RST;
		end
		else
		begin
			if (wr & sel_baud)
				baud_q <= pwdata[15:0];
			if (wr & sel_thr)
				thr_q <= pwdata[7:0];
		end
	end

	// Carrier sense against the programmed threshold
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			carrier_q <= 1'b0;
		else
			carrier_q <= rssi >= thr_q;
	end

	// ****************************************************************
	// Pin input synchronisers
	// ****************************************************************
	logic [SYNC_N-1:0] s1_q;
	logic [SYNC_N-1:0] s2_q;
	logic [SYNC_N-1:0] s3_q;
	logic [SYNC_N-1:0] pin_q;
	logic [SYNC_N-1:0] pinp_q;
	wire  logic [SYNC_N-1:0] raw = {bit_line_pin_i, cfg_serial_in, cfg_sclk, cfg_cs_n};

	// Three stages; a level counts once stages two and three agree
	for (genvar i = 0; i < SYNC_N; i++)
	begin : g_sync
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				s1_q[i]   <= SYNC_RST[i];
				s2_q[i]   <= SYNC_RST[i];
				s3_q[i]   <= SYNC_RST[i];
				pin_q[i]  <= SYNC_RST[i];
				pinp_q[i] <= SYNC_RST[i];
			end
			else
			begin
				s1_q[i]   <= raw[i];
				s2_q[i]   <= s1_q[i];
				s3_q[i]   <= s2_q[i];
				pinp_q[i] <= pin_q[i];
				if (s2_q[i] == s3_q[i])
					pin_q[i] <= s3_q[i];
			end
		end
	end

	// ****************************************************************
	// Config serial port
	// ****************************************************************
	wire logic cs_on   = ~pin_q[0];
	wire logic cs_fall = ~pin_q[0] & pinp_q[0];
	wire logic cs_rise = pin_q[0] & ~pinp_q[0];
	wire logic sck_up  = cs_on & pin_q[1] & ~pinp_q[1];
	wire logic sck_dn  = cs_on & ~pin_q[1] & pinp_q[1];
	logic [7:0] sin_q;
	logic [7:0] sout_q;
	logic       so_q;

	// Shift host bits in on rising clock, status out on falling clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sin_q    <= 8'h00;
			sout_q   <= 8'h00;
			so_q     <= 1'b0;
			ser_rx_q <= 8'h00;
		end
		else
		begin
			if (sck_up)
				sin_q <= {sin_q[6:0], pin_q[2]};
			if (cs_fall)
			begin
				sout_q <= {rssi[6:0], 1'b0};
				so_q   <= rssi[7];
			end
			else if (sck_dn)
			begin
				sout_q <= {sout_q[6:0], 1'b0};
				so_q   <= sout_q[7];
			end
			if (cs_rise)
				ser_rx_q <= sin_q;
		end
	end

	// ****************************************************************
	// Bit clock divider and two-entry buffer
	// ****************************************************************
	logic [15:0] div_q;
	logic        clk_q;
	logic        has_bit_q;
	logic        line_q;
	logic        space_q;
	logic [FIFO_DEPTH-1:0] mem_q;
	logic        wp_q;
	logic        rp_q;
	logic        rdy_q;
	logic        mbit_q;
	logic        mstb_q;

	wire logic tx    = ctrl_q.tx_mode;
	wire logic run   = ~ctrl_q.sleep;
	wire logic tick  = run & (div_q == 16'h0);
	wire logic any   = cnt_q != 2'd0;
	wire logic head  = mem_q[rp_q];
	wire logic try_p = tick & ~tx & (clk_q | ~has_bit_q);
	wire logic rise  = tick & ~clk_q & (tx ? space_q : has_bit_q);
	wire logic push  = tx ? rise : (demod_valid & space_q);
	wire logic pop   = any & (tx ? mod_ready : try_p);
	wire logic in_b  = tx ? pin_q[3] : demod_bit;
	wire logic [1:0] cnt_d = wr_ctrl ? 2'd0 :
		2'(cnt_q + {1'b0, push} - {1'b0, pop});
	// Next room flag and next direction, so that the ready output is a flop
	wire logic space_d = cnt_d < 2'(FIFO_DEPTH);
	wire logic tx_d    = wr_ctrl ? pwdata[0] : tx;

	// Half-period counter, held in sleep
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_q <= 16'h0;
		else if (!run || tick)
			div_q <= 16'(baud_q - 16'h1);
		else
			div_q <= 16'(div_q - 16'h1);
	end

	// Clock phase: stalls low until data or room is there
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_q     <= 1'b0;
			has_bit_q <= 1'b0;
			line_q    <= 1'b0;
		end
		else
		begin
			if (tick & clk_q)
				clk_q <= 1'b0;
			else if (rise)
				clk_q <= 1'b1;
			if (try_p)
				has_bit_q <= any;
			if (try_p & any)
				line_q <= head;
		end
	end

	// Buffer storage; a write of the control word flushes it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_q   <= '0;
			wp_q    <= 1'b0;
			rp_q    <= 1'b0;
			cnt_q   <= 2'd0;
			space_q <= 1'b1;
			rdy_q   <= ~CTRL_RST[0];
		end
		else
		begin
			if (push)
				mem_q[wp_q] <= in_b;
			wp_q    <= wr_ctrl ? 1'b0 : wp_q ^ push;
			rp_q    <= wr_ctrl ? 1'b0 : rp_q ^ pop;
			cnt_q   <= cnt_d;
			space_q <= space_d;
			rdy_q   <= space_d & ~tx_d;
		end
	end

	// Transmit bits toward the modulator
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mbit_q <= 1'b0;
			mstb_q <= 1'b0;
		end
		else
		begin
			mstb_q <= tx & pop;
			if (tx & pop)
				mbit_q <= head;
		end
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	logic bclk_q;
	logic bclk_oe_n_q;
	logic line_o_q;
	logic line_oe_n_q;
	logic lock_q;
	logic lock_oe_n_q;
	logic wake_q;

	wire logic async_c = ctrl_q.async_clk & ~tx;
	wire logic lock_v  = (ctrl_q.lock_mode == LK_GPO) ? ctrl_q.lock_gpo :
		(ctrl_q.lock_mode == LK_RXD) ? line_q : ~synth_locked;
	assign wake = ctrl_q.sleep & ~tx & pin_q[3];

	// Output registers with high impedance in sleep
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bclk_q      <= 1'b0;
			bclk_oe_n_q <= 1'b1;
			line_o_q    <= 1'b0;
			line_oe_n_q <= 1'b1;
			lock_q      <= 1'b1;
			lock_oe_n_q <= 1'b1;
			wake_q      <= 1'b0;
		end
		else
		begin
			bclk_q      <= async_c ? demod_bit : clk_q;
			bclk_oe_n_q <= ctrl_q.sleep;
			line_o_q    <= line_q;
			line_oe_n_q <= ctrl_q.sleep | tx;
			lock_q      <= lock_v;
			lock_oe_n_q <= ctrl_q.sleep;
			wake_q      <= wake & ~wr_ctrl;
		end
	end

	// Port connections
	assign prdata             = prdata_q;
	assign pready             = pready_q;
	assign pslverr            = pslverr_q;
	assign cfg_serial_out     = so_q;
	assign bit_clock_pin_o    = bclk_q;
	assign bit_clock_pin_oe_n = bclk_oe_n_q;
	assign bit_line_pin_o     = line_o_q;
	assign bit_line_pin_oe_n  = line_oe_n_q;
	assign lock_pin_o         = lock_q;
	assign lock_pin_oe_n      = lock_oe_n_q;
	assign ext_rx_amp_ctrl    = ctrl_q.rx_amp;
	assign ext_tx_amp_ctrl    = ctrl_q.tx_amp;
	assign demod_ready        = rdy_q;
	assign mod_bit            = mbit_q;
	assign mod_strobe         = mstb_q;
	assign mod_gauss_en       = ctrl_q.gauss;
	assign wake_strobe        = wake_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_sleep2;
		ctrl_q.sleep ##1 ctrl_q.sleep;
	endsequence

	sleep_hiz_a: assert property (s_sleep2 |-> bit_clock_pin_oe_n
		&& bit_line_pin_oe_n && lock_pin_oe_n)
		else $error("pins not high impedance in sleep");
	line_dir_a: assert property (tx |=> bit_line_pin_oe_n)
		else $error("data line driven in transmit");
	rx_drive_a: assert property (!ctrl_q.sleep && !tx |=> !bit_line_pin_oe_n
		&& bit_line_pin_o == $past(line_q))
		else $error("receive data not on data line");
	lock_ind_a: assert property (ctrl_q.lock_mode == LK_IND
		|=> lock_pin_o == !$past(synth_locked))
		else $error("lock indicator polarity wrong");
	lock_gpo_a: assert property (ctrl_q.lock_mode == LK_GPO
		|=> lock_pin_o == $past(ctrl_q.lock_gpo))
		else $error("lock pin not general output");
	lock_rxd_a: assert property (ctrl_q.lock_mode == LK_RXD
		|=> lock_pin_o == $past(line_q))
		else $error("lock pin not receive data");
	async_clk_a: assert property (async_c |=> bit_clock_pin_o == $past(demod_bit))
		else $error("data clock pin not raw data");
	sleep_clk_a: assert property (s_sleep2 |-> $stable(clk_q))
		else $error("bit clock runs in sleep");
	wake_a: assert property (wake && !wr_ctrl |=> !ctrl_q.sleep && wake_strobe)
		else $error("wake did not leave sleep");
	mod_out_a: assert property (tx && mod_ready && any
		|=> mod_strobe && mod_bit == $past(head))
		else $error("transmit bit not passed on");
	carrier_a: assert property ($stable(rssi) && $stable(thr_q)
		|=> carrier_q == ($past(rssi) >= $past(thr_q)))
		else $error("carrier sense wrong");

endmodule

// File: verification/rdp_host_model.sv
/*
 * Host model: bit-bangs the config port and feeds transmit bits.
 * Assumes the bench resolves the data line from the device's enable alone.
 */
`timescale 1ns/1ps
module rdp_host_model
(
	// Clocks
	input  wire logic        pclk,
	input  wire logic        bit_clk,
	// Data line feed
	input  wire logic        tx_en,
	input  wire logic [31:0] tx_pat,
	input  wire logic        wake,
	output logic             line,
	// Config port
	output logic             cs_n,
	output logic             sclk,
	output logic             sdi,
	input  wire logic        sdo
);
	logic [4:0] idx;
	logic [7:0] rd_q;

	// Idle levels at time zero
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		idx = 5'h00;
	end

	// Transmit bit, or a wake level while receiving
	assign line = tx_en ? tx_pat[idx] : wake;

	// Next transmit bit after each falling data clock
	always @(negedge bit_clk or negedge tx_en)
		if (!tx_en)
			idx <= 5'h00;
		else
			idx <= idx + 5'h01;

	// One byte, MSB first, sclk half period of 8 pclk
	task xfer(input logic [7:0] b);
		int i;
		@(posedge pclk);
		cs_n <= 1'b0;
		for (i = 7; i >= 0; i--)
		begin
			sdi <= b[i];
			repeat (8) @(posedge pclk);
			sclk <= 1'b1;
			rd_q = {rd_q[6:0], sdo};
			repeat (8) @(posedge pclk);
			sclk <= 1'b0;
		end
		repeat (8) @(posedge pclk);
		cs_n <= 1'b1;
		repeat (12) @(posedge pclk);
	endtask
endmodule

// File: verification/tb_radio_digital_pin_functions.sv
/*
 * Self-checking bench of the radio pin-function block over APB.
 * Assumes the design package and the host model beside it.
 */
`timescale 1ns/1ps
module tb_radio_digital_pin_functions
	import rdp_pkg::*;
;
	localparam logic [15:0] BAUD = 16'h0008;

	logic        pclk, presetn, psel, penable, pwrite, synth_locked, demod_bit, demod_valid;
	logic        mod_ready, cfg_cs_n, cfg_sclk, cfg_serial_in, cfg_serial_out, pready, pslverr;
	logic        bit_clock_pin_o, bit_clock_pin_oe_n, bit_line_pin_o, bit_line_pin_oe_n;
	logic        lock_pin_o, lock_pin_oe_n, ext_rx_amp_ctrl, ext_tx_amp_ctrl, demod_ready;
	logic        mod_bit, mod_strobe, mod_gauss_en, wake_strobe, host_wake, host_line;
	logic        tx_en, rx_on, tx_on, clk_q, b, rerr;
	logic [7:0]  paddr, rssi, t;
	logic [15:0] seed, rseed;
	logic [31:0] pwdata, prdata, rdat, tx_pat, m;
	rdp_ctrl_s   c;
	int          n_mismatch, total_checks, cyc, n_wake, n_full, n_tx, i, j, k;
	logic        rxq[$];
	wire logic   bit_line_pin_i = bit_line_pin_oe_n ? host_line : bit_line_pin_o;

	rdp_pinfunc #(.BAUD_DEF(BAUD)) dut
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cfg_cs_n, .cfg_sclk, .cfg_serial_in, .cfg_serial_out, .bit_clock_pin_o,
		.bit_clock_pin_oe_n, .bit_line_pin_i, .bit_line_pin_o, .bit_line_pin_oe_n,
		.lock_pin_o, .lock_pin_oe_n, .ext_rx_amp_ctrl, .ext_tx_amp_ctrl, .synth_locked,
		.rssi, .demod_bit, .demod_valid, .demod_ready, .mod_ready, .mod_bit, .mod_strobe,
		.mod_gauss_en, .wake_strobe
	);

	rdp_host_model host
	(
		.pclk, .bit_clk(bit_clock_pin_o), .tx_en, .tx_pat, .wake(host_wake),
		.line(host_line), .cs_n(cfg_cs_n), .sclk(cfg_sclk), .sdi(cfg_serial_in),
		.sdo(cfg_serial_out)
	);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Expected lock, gauss, amps and enables for a control word
	function automatic logic [31:0] exp_pins(input rdp_ctrl_s v, input logic lk);
		logic lock;
		lock = (v.lock_mode == LK_GPO) ? v.lock_gpo : ~lk;
		return 32'({lock, v.gauss, v.tx_amp, v.rx_amp, v.sleep, v.sleep | v.tx_mode, v.sleep});
	endfunction

	function automatic logic [31:0] pins();
		return 32'({lock_pin_o, mod_gauss_en, ext_tx_amp_ctrl, ext_rx_amp_ctrl,
			bit_clock_pin_oe_n, bit_line_pin_oe_n, lock_pin_oe_n});
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; waits for pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ends on pready; if pready never comes, only the bench timeout ends it
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task apb_rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
		chk(32'(rerr), 32'(ee));
	endtask

	task tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ****************************************************************
	// Clock, timeout, monitors
	// ****************************************************************
	always #2.5 pclk = ~pclk;

	// Ceiling on run length, random modulator stalls
	always @(posedge pclk)
	begin
		cyc++;
		rseed <= lfsr(rseed);
		mod_ready <= rseed[0] | rseed[1];
		if (cyc == 20000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// Receive bits at rising data clock, modulator bits, wake pulses
	always @(posedge pclk)
	begin
		clk_q <= bit_clock_pin_o;
		if (rx_on && bit_clock_pin_o === 1'b1 && clk_q === 1'b0 && rxq.size() > 0)
		begin
			b = rxq.pop_front();
			chk(32'(bit_line_pin_o), 32'(b));
			chk(32'(lock_pin_o), 32'(b));
		end
		if (demod_valid && demod_ready === 1'b0)
			n_full++;
		if (tx_on && mod_strobe === 1'b1 && n_tx < 32)
		begin
			chk(32'(mod_bit), 32'(tx_pat[n_tx]));
			n_tx++;
		end
		if (wake_strobe === 1'b1)
			n_wake++;
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, synth_locked, demod_bit, demod_valid} = 8'h00;
		{mod_ready, host_wake, tx_en, rx_on, tx_on, paddr, rssi, pwdata} = 53'h0;
		tx_pat = 32'h0;
		seed = 16'h6987;
		rseed = 16'h6987;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(32'({bit_clock_pin_oe_n, bit_line_pin_oe_n, lock_pin_oe_n, lock_pin_o}), 32'hf);
		apb_rd(OFF_CTRL, 32'(CTRL_RST), 1'b0);
		apb_rd(OFF_BAUD, 32'(BAUD), 1'b0);
		apb_rd(OFF_THR, 32'(THR_RST), 1'b0);
		apb(1'b1, OFF_SER, 32'hff);
		apb_rd(OFF_SER, 32'h0, 1'b0);
		apb_rd(8'h14, 32'h0, 1'b1);
		// Wake from sleep by a host level on the data line
		host_wake <= 1'b1;
		repeat (12) @(posedge pclk);
		chk(32'(n_wake), 32'h1);
		host_wake <= 1'b0;
		apb(1'b0, OFF_STAT, 32'h0);
		chk(32'(rdat[ST_SLP]), 32'h0);
		// Random control words: pin roles, amps, sleep
		for (i = 0; i < 12; i++)
		begin
			seed = lfsr(seed);
			c = rdp_ctrl_s'(seed[8:0]);
			if (c.lock_mode == LK_RXD)
				c.lock_mode = LK_RSV;
			synth_locked <= seed[15];
			apb(1'b1, OFF_CTRL, 32'(c));
			repeat (3) @(posedge pclk);
			m = c.sleep ? 32'h3f : 32'h7f;
			chk(pins() & m, exp_pins(c, seed[15]) & m);
			synth_locked <= ~seed[15];
			repeat (3) @(posedge pclk);
			chk(pins() & m, exp_pins(c, ~seed[15]) & m);
			apb_rd(OFF_CTRL, 32'(c), 1'b0);
		end
		// Config port read-out and signal strength
		seed = lfsr(seed);
		rssi <= seed[7:0];
		host.xfer(seed[15:8]);
		chk(32'(host.rd_q), 32'(seed[7:0]));
		apb_rd(OFF_SER, 32'(seed[15:8]), 1'b0);
		for (j = 0; j < 2; j++)
		begin
			t = seed[7:0] + 8'(j);
			apb(1'b1, OFF_THR, 32'(t));
			apb(1'b0, OFF_STAT, 32'h0);
			chk(32'(rdat[ST_LOCK:0]), 32'({synth_locked, seed[7:0] >= t, seed[7:0]}));
		end
		// Receive stream with lock pin as data; buffer fills and drains
		apb(1'b1, OFF_CTRL, 32'h008);
		// Let a clock phase left high by an earlier mode fall before checking
		repeat (20) @(posedge pclk);
		rx_on <= 1'b1;
		for (i = 0; i < 24; i++)
		begin
			seed = lfsr(seed);
			demod_bit <= seed[0];
			demod_valid <= 1'b1;
			do
				@(posedge pclk);
			while (demod_ready !== 1'b1);
			rxq.push_back(seed[0]);
		end
		demod_valid <= 1'b0;
		for (k = 0; k < 3000 && rxq.size() > 0; k++)
			@(posedge pclk);
		chk(32'(rxq.size()), 32'h0);
		chk(32'(n_full != 0), 32'h1);
		rx_on <= 1'b0;
		apb(1'b0, OFF_STAT, 32'h0);
		chk(32'(rdat[12:11]), 32'h0);
		// Asynchronous mode: raw data on the clock pin
		apb(1'b1, OFF_CTRL, 32'h010);
		for (j = 1; j >= 0; j--)
		begin
			demod_bit <= j[0];
			repeat (4) @(posedge pclk);
			chk(32'(bit_clock_pin_o), 32'(j[0]));
		end
		// Transmit stream with modulator stalls
		tx_pat <= {seed, lfsr(seed)};
		tx_en <= 1'b1;
		tx_on <= 1'b1;
		// Park in transmit sleep so the host owns the line before the first sample
		apb(1'b1, OFF_CTRL, 32'h003);
		repeat (8) @(posedge pclk);
		apb(1'b1, OFF_CTRL, 32'h001);
		for (k = 0; k < 4000 && n_tx < 20; k++)
			@(posedge pclk);
		chk(32'(n_tx >= 20), 32'h1);
		tally_and_finish();
	end
endmodule
